/* hw/subranging_adc_output_pipeline.sv */
// clocked digital side of an 8-bit two-step subranging converter
// How it works
// - coarse nibble then fine nibble per sample
// - input captured on mclk falling edge
// - coarse result final at next rising edge
// - fine reference derived from coarse result
// - fine result final one rising edge later
// - joined word out at third rising edge
// - groups leave sample phase on their first load, then alternate hold and compare phases
// - sample_word always driven; sample_word_oe set three rising edges after enable_n goes low
// - straight binary code rising with input
`timescale 1ns/10ps
`default_nettype none
module subranging_adc_output_pipeline
(
   input  wire logic                              mclk,
   input  wire logic                              rst_n,
   input  wire logic [subrange_pkg::WORD_W-1:0]   input_level,
   input  wire logic                              output_enable_n,
   output var  logic [subrange_pkg::WORD_W-1:0]   sample_word,
   output var  logic                              sample_word_oe,
   output var  logic                              sample_word_valid
);

   // falling edge capture state
   logic [subrange_pkg::WORD_W-1:0] coarse_hold;
   logic [subrange_pkg::WORD_W-1:0] fine_hold [subrange_pkg::BANKS];
   logic                            cap_bank;
   logic                            cap_seen;
   logic [subrange_pkg::WORD_W-1:0] next_coarse_hold;
   logic [subrange_pkg::WORD_W-1:0] next_fine_hold [subrange_pkg::BANKS];
   logic                            next_cap_bank;
   logic                            next_cap_seen;

   // rising edge pipeline state
   logic [subrange_pkg::HALF_W-1:0] coarse_result;
   logic [subrange_pkg::WORD_W-1:0] fine_reference;
   logic                            coarse_valid;
   subrange_pkg::split_word_t       joined;
   logic                            joined_valid;
   subrange_pkg::phase_t            fine_phase [subrange_pkg::BANKS];
   logic                            en_meta;
   logic                            en_sync;
   logic [subrange_pkg::HALF_W-1:0] next_coarse_result;
   logic [subrange_pkg::WORD_W-1:0] next_fine_reference;
   logic                            next_coarse_valid;
   subrange_pkg::split_word_t       next_joined;
   logic                            next_joined_valid;
   subrange_pkg::phase_t            next_fine_phase [subrange_pkg::BANKS];
   logic [subrange_pkg::WORD_W-1:0] next_sample_word;
   logic                            next_sample_word_oe;
   logic                            next_sample_word_valid;

   // output stage state
   logic                            next_en_meta;
   logic                            next_en_sync;

   // residue of the held level within the selected sub-range
   function automatic logic [subrange_pkg::HALF_W-1:0] fine_of
   (
      input logic [subrange_pkg::WORD_W-1:0] level,
      input logic [subrange_pkg::WORD_W-1:0] base
   );
      logic [subrange_pkg::WORD_W-1:0] diff;
      diff    = level - base;
      fine_of = diff[subrange_pkg::HALF_W-1:0];
   endfunction

   // upper nibble resolved by the coarse group
   function automatic logic [subrange_pkg::HALF_W-1:0] coarse_of
   (
      input logic [subrange_pkg::WORD_W-1:0] level
   );
      coarse_of = level[subrange_pkg::WORD_W-1:subrange_pkg::HALF_W];
   endfunction

   // bottom of the sub-range picked by a coarse result
   function automatic logic [subrange_pkg::WORD_W-1:0] range_base
   (
      input logic [subrange_pkg::HALF_W-1:0] coarse
   );
      range_base = {coarse, subrange_pkg::NIBBLE_ZERO};
   endfunction

   // one rising edge of a group's sample, hold, compare cycle
   function automatic subrange_pkg::phase_t phase_step
   (
      input subrange_pkg::phase_t ph,
      input logic                 loaded
   );
      phase_step = subrange_pkg::PH_SAMPLE;
      case (ph)
         subrange_pkg::PH_SAMPLE:
            phase_step = subrange_pkg::PH_SAMPLE;
         subrange_pkg::PH_HOLD:
            phase_step = subrange_pkg::PH_COMPARE;
         subrange_pkg::PH_COMPARE:
            phase_step = subrange_pkg::PH_SAMPLE;
         default:
            phase_step = subrange_pkg::PH_SAMPLE;
      endcase
      // a fresh load starts the hold phase
      if (loaded)
         phase_step = subrange_pkg::PH_HOLD;
   endfunction

   // capture side
   always_comb
   begin
      next_coarse_hold = coarse_hold;
      next_fine_hold   = fine_hold;
      next_cap_bank    = cap_bank;
      next_cap_seen    = cap_seen;
      if (!rst_n)
      begin
         next_coarse_hold = subrange_pkg::WORD_ZERO;
         for (int b = 0; b < subrange_pkg::BANKS; b++)
         begin
            next_fine_hold[b] = subrange_pkg::WORD_ZERO;
         end
         next_cap_bank    = 1'b0;
         next_cap_seen    = 1'b0;
      end
      else
      begin
         // sample into coarse and chosen fine group
         next_coarse_hold           = input_level;
         next_fine_hold[cap_bank ^ 1'b1] = input_level;
         next_cap_bank              = cap_bank ^ 1'b1;
         next_cap_seen              = 1'b1;
      end
   end

   always_ff @(negedge mclk)
   begin
      coarse_hold <= next_coarse_hold;
      fine_hold   <= next_fine_hold;
      cap_bank    <= next_cap_bank;
      cap_seen    <= next_cap_seen;
   end

   // rising edge pipeline
   always_comb
   begin
      next_coarse_result     = coarse_result;
      next_fine_reference    = fine_reference;
      next_coarse_valid      = coarse_valid;
      next_joined            = joined;
      next_joined_valid      = joined_valid;
      next_fine_phase        = fine_phase;
      if (!rst_n)
      begin
         next_coarse_result     = subrange_pkg::NIBBLE_ZERO;
         next_fine_reference    = subrange_pkg::WORD_ZERO;
         next_coarse_valid      = 1'b0;
         next_joined            = '0;
         next_joined_valid      = 1'b0;
         for (int b = 0; b < subrange_pkg::BANKS; b++)
         begin
            next_fine_phase[b] = subrange_pkg::PH_SAMPLE;
         end
      end
      else
      begin
         // upper nibble settles from coarse group
         next_coarse_result  = coarse_of(coarse_hold);
         next_coarse_valid   = cap_seen;
         next_fine_reference = range_base(next_coarse_result);
         for (int b = 0; b < subrange_pkg::BANKS; b++)
         begin
            next_fine_phase[b] =
               phase_step(fine_phase[b], cap_seen && (b == int'(cap_bank)));
         end
         // fine nibble from the group leaving hold
         for (int b = 0; b < subrange_pkg::BANKS; b++)
         begin
            if (fine_phase[b] == subrange_pkg::PH_HOLD)
               next_joined.fine = fine_of(fine_hold[b], fine_reference);
         end
         next_joined.coarse = coarse_result;
         next_joined_valid  = coarse_valid;
      end
   end

   always_ff @(posedge mclk)
   begin
      coarse_result     <= next_coarse_result;
      fine_reference    <= next_fine_reference;
      coarse_valid      <= next_coarse_valid;
      joined            <= next_joined;
      joined_valid      <= next_joined_valid;
      fine_phase        <= next_fine_phase;
   end

   // output stage and enable synchroniser
   always_comb
   begin
      next_en_meta           = output_enable_n;
      next_en_sync           = en_meta;
      next_sample_word       = joined;
      next_sample_word_valid = joined_valid;
      next_sample_word_oe    = ~en_sync;
      if (!rst_n)
      begin
         next_sample_word       = subrange_pkg::WORD_ZERO;
         next_sample_word_valid = 1'b0;
         next_sample_word_oe    = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      en_meta           <= next_en_meta;
      en_sync           <= next_en_sync;
      sample_word       <= next_sample_word;
      sample_word_oe    <= next_sample_word_oe;
      sample_word_valid <= next_sample_word_valid;
   end

endmodule
`default_nettype wire

/* hw/subrange_pkg.sv */
// shared widths, phases and carriers of the two-step converter pipeline
package subrange_pkg;
   localparam int  HALF_W     = 4;
   localparam int  WORD_W     = 8;
   localparam int  BANKS      = 2;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;
   localparam logic [7:0] WORD_ZERO   = 8'h00;

   typedef enum logic [1:0] {
      PH_SAMPLE  = 2'b00,
      PH_HOLD    = 2'b01,
      PH_COMPARE = 2'b10
   } phase_t;

   typedef struct packed {
      logic [HALF_W-1:0] coarse;
      logic [HALF_W-1:0] fine;
   } split_word_t;
endpackage

/* tb/word_chk.sv */
// port assertions for the converter pipeline
`timescale 1ns/10ps
`default_nettype none
module word_chk
(
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic [7:0] input_level,
   input wire logic       output_enable_n,
   input wire logic [7:0] sample_word,
   input wire logic       sample_word_oe,
   input wire logic       sample_word_valid
);
   default clocking dc @(negedge mclk); endclocking
   default disable iff (!rst_n);
   sequence en_low4; (!output_enable_n && $past(rst_n, 4)) [*4]; endsequence
   word_lat_a: assert property (sample_word_valid |->
      sample_word == $past(input_level, 3)) else $error("bad word");
   coarse_half_a: assert property (sample_word_valid |->
      sample_word[7:4] == $past(input_level[7:4], 3)) else $error("coarse");
   fine_half_a: assert property (sample_word_valid |->
      sample_word[3:0] == $past(input_level[3:0], 3)) else $error("fine");
   valid_start_a: assert property ($rose(sample_word_valid) |->
      $past(rst_n, 3) && !$past(rst_n, 4)) else $error("valid early");
   valid_hold_a: assert property (sample_word_valid |=>
      sample_word_valid) else $error("valid lost");
   drive_on_a: assert property ($fell(output_enable_n) |->
      ##[1:4] sample_word_oe) else $error("drive late");
   drive_off_a: assert property ($rose(output_enable_n) |->
      ##[1:4] !sample_word_oe) else $error("release late");
   drive_hold_a: assert property (en_low4 |-> sample_word_oe)
      else $error("not driving");
endmodule
`default_nettype wire

/* tb/word_sink.sv */
// downstream consumer: owns the enable pin and resolves the data bus
`timescale 1ns/10ps
`default_nettype none
module word_sink
(
   input  wire logic       want_n,
   input  wire logic [7:0] sample_word,
   input  wire logic       sample_word_oe,
   output logic            output_enable_n,
   output logic [7:0]      bus
);
   assign output_enable_n = want_n;
   assign bus = sample_word_oe ? sample_word : ~sample_word;
endmodule
`default_nettype wire

/* tb/subranging_adc_output_pipeline_bench.sv */
// self-checking bench for the converter pipeline
`timescale 1ns/10ps
`default_nettype none
module subranging_adc_output_pipeline_bench;
   logic        mclk = 1'b0, rst_n = 1'b0, want_n = 1'b1;
   logic        output_enable_n, sample_word_oe, sample_word_valid;
   logic [7:0]  input_level = 8'h00, sample_word, bus;
   logic [31:0] lf = 32'h3CFA, hist = 32'h0;
   int          fail_count, total_checks, cyc, since;
   always #5 mclk = ~mclk;
   function automatic logic [31:0] step(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [7:0] ew(logic [7:0] v); return v; endfunction
   task automatic chk_word(logic [7:0] g, logic [7:0] e);
      total_checks++;
      fail_count += int'(g !== e);
      if (g !== e) $display("ERROR %0t got %h exp %h", $time, g, e);
   endtask
   task automatic chk_flag(logic g, logic e);
      total_checks++;
      fail_count += int'(g !== e);
      if (g !== e) $display("ERROR %0t got %h exp %h", $time, g, e);
   endtask
   task automatic summarize(int extra);
      fail_count += extra;
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   subranging_adc_output_pipeline subranging_adc_output_pipeline_inst
   (
      .mclk              (mclk),
      .rst_n             (rst_n),
      .input_level       (input_level),
      .output_enable_n   (output_enable_n),
      .sample_word       (sample_word),
      .sample_word_oe    (sample_word_oe),
      .sample_word_valid (sample_word_valid)
   );
   word_sink word_sink_inst
   (
      .want_n          (want_n),
      .sample_word     (sample_word),
      .sample_word_oe  (sample_word_oe),
      .output_enable_n (output_enable_n),
      .bus             (bus)
   );
   always @(posedge mclk) if (++cyc > 2000) summarize(1);
   initial
      for (int i = -5; i < 400; i++)
      begin
         @(negedge mclk);
         since = rst_n ? since + 1 : 0;
         hist = {hist[23:0], ew(input_level)};
         if (since == 0 && i > -5)
         begin
            chk_word(sample_word, 8'h00);
            chk_flag(sample_word_oe, 1'b0);
         end
         if (i > -5)
            chk_flag(sample_word_valid, since > 3);
         if (since > 3)
            chk_word(sample_word, hist[31:24]);
         if (since > 4 && i[4:0] > 5)
            chk_flag(sample_word_oe, !want_n);
         if (since > 3 && sample_word_oe === 1'b1)
            chk_word(bus, hist[31:24]);
         lf = step(lf);
         input_level <= (i < 4) ? {i[0], {7{i[1]}}} : lf[15:8];
         want_n <= i[5];
         rst_n <= i >= 0 && (i < 200 || i > 203);
         if (i == 399) summarize(0);
      end
endmodule
bind subranging_adc_output_pipeline word_chk word_chk_inst
(
   .mclk              (mclk),
   .rst_n             (rst_n),
   .input_level       (input_level),
   .output_enable_n   (output_enable_n),
   .sample_word       (sample_word),
   .sample_word_oe    (sample_word_oe),
   .sample_word_valid (sample_word_valid)
);
`default_nettype wire
